// ### dv/fine_scale_power_ramp_tb.sv
`timescale 1ns/1ps
module fine_scale_power_ramp_tb;
  import fsr_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, regRdEn = 1'b0, serialSync = 1'b0;
  logic        legacyMode = 1'b0, pendingModeBit = 1'b0, run = 1'b0;
  logic [3:0]  syncPins = 4'h0;
  logic [11:0] regRdAddr = 12'h0;
  logic [17:0] regRdData;
  logic [16:0] v;
  fsr_reg_wr_s regWr = '0;
  fsr_ext_wr_s extWr = '0;
  fsr_sample_s sampleIn, outSample;
  logic        sampleValid, outValid, inputHalt, activeModeBit, beamSyncOut, rampBusy;
  int          err_count = 0, num_checks = 0, fs = 65536, hold = 16384, n, c;
  int          cf[4];
  int          cq[$];
  logic [31:0] eq[$];

  always #2 clk = ~clk;

  fsr_fine_scale_ramp #(.CHANNEL(0)) u_fsr_fine_scale_ramp (.clk(clk), .reset_n(reset_n),
    .regWr(regWr), .regRdEn(regRdEn), .regRdAddr(regRdAddr), .regRdData(regRdData), .extWr(extWr),
    .sampleValid(sampleValid), .sampleIn(sampleIn), .serialSync(serialSync), .syncPins(syncPins),
    .legacyMode(legacyMode), .pendingModeBit(pendingModeBit), .outValid(outValid),
    .outSample(outSample), .inputHalt(inputHalt), .activeModeBit(activeModeBit),
    .beamSyncOut(beamSyncOut), .rampBusy(rampBusy));
  fsr_filter_model u_fsr_filter_model (.clk(clk), .run(run), .sampleValid(sampleValid),
    .sampleIn(sampleIn));

  task chk(logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Truncating arithmetic with saturation of the fine-scaled value, as the datapath does it.
  function automatic logic [15:0] ev(int x, int k);
    longint f;
    f = (longint'(x) * fs) >>> 16;
    f = (f > 32767) ? 32767 : ((f < -32768) ? -32768 : f);
    return (k < 0) ? 16'h0 : 16'((f * k) >>> 14);
  endfunction

  function automatic int cv(int s, int ip);
    if (ip == 0) return cf[s];
    if (s == 7) return cf[3];
    return s[0] ? (cf[s/2] + cf[s/2+1]) / 2 : cf[s/2];
  endfunction

  always @(posedge clk) begin
    if (sampleValid) begin
      c = (cq.size() != 0) ? cq.pop_front() : hold;
      if (c < 0) chk(inputHalt, 1'b1);
      eq.push_back({ev(int'(sampleIn.i), c), ev(int'(sampleIn.q), c)});
    end
    if (outValid && eq.size() != 0) chk(outSample, eq.pop_front());
  end

  task wr(logic [11:0] a, logic [17:0] d);
    @(negedge clk) regWr <= '{1'b1, a, d};
    @(negedge clk) regWr.en <= 1'b0;
  endtask

  task rd(logic [11:0] a, logic [17:0] e);
    @(negedge clk) {regRdEn, regRdAddr} <= {1'b1, a};
    @(negedge clk) regRdEn <= 1'b0;
    chk(regRdData, e);
  endtask

  task sy(int k);
    @(negedge clk) {serialSync, syncPins} <= 5'(1 << k);
    @(negedge clk) {serialSync, syncPins} <= 5'h0;
  endtask

  task ex(logic [7:0] d);
    @(negedge clk) extWr <= '{1'b1, SOFT_SYNC_ADDR, d};
    @(negedge clk) extWr.en <= 1'b0;
  endtask

  task bc(logic [31:0] e);
    n = 0;
    repeat (4) begin
      n += beamSyncOut;
      @(negedge clk);
    end
    chk(n, e);
  endtask

  task feed(int k);
    run <= 1'b1;
    repeat (4 * k) @(negedge clk);
    run <= 1'b0;
    repeat (6) @(negedge clk);
  endtask

  initial begin
    void'($urandom(29162));
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    rd(12'h00e, 18'(FS_RESET));
    rd(12'h0ff, 18'h0);
    for (int lm = 0; lm < 2; lm++) begin
      v = 17'($urandom());
      legacyMode = lm[0];
      wr(12'h00e, 18'(v));
      wr(12'h00f, 18'h10000);
      wr(12'h019, 18'h5);
      wr(12'h016, 18'h0);
      sy(1);
      repeat (8) @(negedge clk);
      fs = lm ? 2 * v[15:0] : v;
      rd(12'h00e, 18'(v));
      feed(6);
    end
    for (int k = 0; k < 4; k++) begin
      cf[k] = $urandom() & 32'h3fff;
      wr(12'h040 + 12'(k), 18'(cf[k]));
    end
    wr(12'h017, 18'h3);
    wr(12'h018, 18'h2);
    wr(12'h019, 18'h3);
    pendingModeBit = 1'b1;
    for (int ip = 0; ip < 2; ip++) begin
      wr(12'h016, 18'(5 + 2 * ip));
      sy(4);
      n = 0;
      while (rampBusy !== 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      chk(n, 3);
      // A second trigger lands while the ramp runs down; it must not restart the sequence.
      sy(4);
      repeat (4) @(negedge clk);
      for (int s = 4 * (1 + ip) - 1; s >= 0; s--) cq.push_back(cv(s, ip));
      cq.push_back(-1);
      cq.push_back(-1);
      for (int s = 0; s < 4 * (1 + ip); s++) cq.push_back(cv(s, ip));
      hold = cf[3];
      feed(26);
      chk(rampBusy, 1'b0);
      chk(activeModeBit, 1'b1);
    end
    wr(12'h016, 18'h0);
    wr(12'h001, 18'hc1);
    rd(12'h001, 18'hc1);
    sy(0);
    bc(1);
    rd(12'h001, 18'h0);
    sy(0);
    bc(0);
    ex(8'h42);
    bc(0);
    ex(8'h41);
    bc(1);
    wr(12'h019, 18'h800);
    for (int k = 1; k < 4; k++) begin
      wr(12'h00f, 18'(k << 16));
      sy(k);
      @(negedge clk);
      // Two decrements pass between the load and the read.
      rd(12'h01a, 18'h107fe);
    end
    wr(12'h019, 18'h0);
    sy(3);
    repeat (3) @(negedge clk);
    rd(12'h01a, 18'h10000);
    results();
  end

  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule

// ### dv/fsr_filter_model.sv
`timescale 1ns/1ps
module fsr_filter_model
  import fsr_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   run,
  output logic        sampleValid,
  output fsr_sample_s sampleIn
);
  int gap = 0;
  initial begin
    sampleValid = 1'b0;
    sampleIn = '0;
  end
  // Samples come four clocks apart, above the two-cycle spacing a running ramp needs.
  always @(negedge clk) begin
    sampleValid <= 1'b0;
    gap <= (gap == 3) ? 0 : gap + 1;
    if (run && gap == 0) begin
      sampleValid <= 1'b1;
      sampleIn <= $urandom();
    end
  end
endmodule

// ### verilog/fsr_coeff_mem.sv
`timescale 1ns/1ps
module fsr_coeff_mem
  import fsr_pkg::*;
#(
  parameter int WIDTH = COEFF_W,
  parameter int DEPTH = COEFF_DEPTH
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("fsr_coeff_mem: unsupported size");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // The array carries no reset; software loads it before enabling the ramp.
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

// ### verilog/fsr_fine_scale_ramp.sv
`timescale 1ns/1ps
// Summary of operation
// - Multiply samples by fine scale in [0,2), step 2^-16 native, 2^-15 legacy.
// - Ramp coefficients are 14-bit unsigned fractions in [0,1).
// - Memory holds 64 coefficients; programmed length 0..63 selects how many are used, 1..64.
// - Interpolation bit inserts midpoints, up to 128 steps, doubling ramp duration.
// - Ramp enable low bypasses the ramp multiplier, passing fine-scaled data unchanged.
// - One ramp coefficient applied per filter output sample.
// - Trigger starts ramp-down from last programmed coefficient back to first.
// - Rest of 0..32 samples follows; mode updates and input sampling halts.
// - Ramp-up runs first to last, then output holds at last coefficient gain.
// - A time-slot sync loads the 16-bit hold-off counter with the programmed value.
// - Counter decrements each clock; at one it triggers ramp and scale update.
// - A zero load bypasses the counter: no trigger, no scale update.
// - With serial sync enabled, serial word sync bits load the counter.
// - Two-bit select picks one of four sync pins as time-slot sync.
// - Pin-zero and software beam syncs reach both time-slot and beam logic.
// - Serial sync ORed with the pin multiplexer output loads the counter.
// - Software beam sync bit loads fine scale and beam hold-off counters.
// - Four routing bits deliver software sync only to selected channels.
// - Common 8-bit mask gates pin-zero syncs per channel and per multiplexer.
// - First-sync-only flag passes one pin-zero pulse then clears whole mask.
// - Sync pins one to three reach every multiplexer unmasked.
module fsr_fine_scale_ramp
  import fsr_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire fsr_reg_wr_s       regWr,
  input  wire logic              regRdEn,
  input  wire logic [ADDR_W-1:0] regRdAddr,
  output logic      [DATA_W-1:0] regRdData,
  input  wire fsr_ext_wr_s       extWr,
  input  wire logic              sampleValid,
  input  wire fsr_sample_s       sampleIn,
  input  wire logic              serialSync,
  input  wire logic [3:0]        syncPins,
  input  wire logic              legacyMode,
  input  wire logic              pendingModeBit,
  output logic                   outValid,
  output fsr_sample_s            outSample,
  output logic                   inputHalt,
  output logic                   activeModeBit,
  output logic                   beamSyncOut,
  output logic                   rampBusy
);

  if (CHANNEL < 0 || CHANNEL > 3) begin : g_bad_channel
    $error("fsr_fine_scale_ramp: CHANNEL must be 0 to 3");
  end

  localparam logic [3:0] CH_PAGE = 4'(CHANNEL);

  // Interpolated steps pair a stored word with its neighbour toward the top.
  function automatic fsr_fetch_s mkFetch(input logic [STEP_W-1:0] s,
                                         input logic              interp,
                                         input logic [LEN_W-1:0]  lenm1,
                                         input logic              up,
                                         input logic              self);
    fsr_fetch_s f;
    f.valid = 1'b1;
    f.odd   = interp & s[0];
    f.self  = self;
    if (!interp) begin
      f.addr = s[LEN_W-1:0];
    end else if (s[0] && up && s[STEP_W-1:1] != lenm1) begin
      f.addr = LEN_W'(s[STEP_W-1:1] + 6'h01);
    end else begin
      f.addr = s[STEP_W-1:1];
    end
    return f;
  endfunction

  function automatic logic [COEFF_W-1:0] coeffAvg(input logic [COEFF_W-1:0] a,
                                                  input logic [COEFF_W-1:0] b);
    logic [COEFF_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    return sum[COEFF_W:1];
  endfunction

  // Register file.
  logic [7:0]           syncMask_r,  syncMask_nxt;
  logic [FS_W-1:0]      fsPending_r, fsPending_nxt;
  logic [FS_W-1:0]      fsActive_r,  fsActive_nxt;
  logic [1:0]           syncSel_r,   syncSel_nxt;
  logic [2:0]           rampCtrl_r,  rampCtrl_nxt;
  logic [LEN_W-1:0]     rampLen_r,   rampLen_nxt;
  logic [LEN_W-1:0]     restLen_r,   restLen_nxt;
  logic [HOLDOFF_W-1:0] holdValue_r, holdValue_nxt;
  logic [DATA_W-1:0]    rdData_nxt;
  // Sync and hold-off.
  logic [HOLDOFF_W-1:0] holdCnt_r,   holdCnt_nxt;
  logic                 beamSync_nxt;
  logic                 sync0Pass;
  logic                 softBeam;
  logic                 muxSync;
  logic                 tsLoad;
  logic                 holdTrig;
  // Ramp sequencer.
  fsr_ramp_e            state_r,     state_nxt;
  logic [STEP_W-1:0]    step_r,      step_nxt;
  logic [LEN_W-1:0]     restCnt_r,   restCnt_nxt;
  logic [COEFF_W-1:0]   coeff_r,     coeff_nxt;
  fsr_fetch_s           pend_r,      fetchReq;
  logic                 mode_nxt;
  logic                 halt_nxt;
  logic                 busy_nxt;
  logic [STEP_W-1:0]    topStep;
  logic [COEFF_W-1:0]   memRdData;
  logic [RAMP_W-1:0]    appliedCoeff;
  logic [FS_W-1:0]      fsFactor;
  logic                 fsValid;
  fsr_sample_s          fsSample;
  logic                 chWr;
  logic                 coeffWr;
  logic                 rampEn;
  logic                 interp;

  assign chWr    = regWr.en && regWr.addr[ADDR_W-1:8] == CH_PAGE;
  assign coeffWr = chWr && regWr.addr[7:6] == COEFF_PAGE;
  assign rampEn  = rampCtrl_r[RAMP_EN_BIT];
  assign interp  = rampCtrl_r[RAMP_INTERP_BIT];

  always_comb begin
    syncMask_nxt  = syncMask_r;
    fsPending_nxt = fsPending_r;
    syncSel_nxt   = syncSel_r;
    rampCtrl_nxt  = rampCtrl_r;
    rampLen_nxt   = rampLen_r;
    restLen_nxt   = restLen_r;
    holdValue_nxt = holdValue_r;
    // Only one pin-zero pulse passes in first-only mode; a host write in the same cycle wins.
    if (sync0Pass && syncMask_r[FIRST_ONLY_BIT]) begin
      syncMask_nxt = SYNC_MASK_RESET;
    end
    if (regWr.en && regWr.addr == COMMON_MASK_ADDR) begin
      syncMask_nxt = regWr.data[7:0];
    end
    if (chWr) begin
      case (regWr.addr[7:0])
        FINE_SCALE_OFS: fsPending_nxt = regWr.data[FS_W-1:0];
        SYNC_SEL_OFS:   syncSel_nxt   = regWr.data[SYNC_SEL_LSB+1:SYNC_SEL_LSB];
        RAMP_CTRL_OFS:  rampCtrl_nxt  = regWr.data[2:0];
        RAMP_LEN_OFS:   rampLen_nxt   = regWr.data[LEN_W-1:0];
        REST_LEN_OFS:   restLen_nxt   = (regWr.data[LEN_W-1:0] > REST_MAX) ? REST_MAX : regWr.data[LEN_W-1:0];
        HOLDOFF_OFS:    holdValue_nxt = regWr.data[HOLDOFF_W-1:0];
        default: ;
      endcase
    end
    rdData_nxt = regRdData;
    if (regRdEn) begin
      rdData_nxt = '0;
      if (regRdAddr == COMMON_MASK_ADDR) begin
        rdData_nxt = DATA_W'(syncMask_r);
      end else if (regRdAddr[ADDR_W-1:8] == CH_PAGE) begin
        case (regRdAddr[7:0])
          FINE_SCALE_OFS: rdData_nxt = DATA_W'(fsPending_r);
          SYNC_SEL_OFS:   rdData_nxt = {syncSel_r, 16'h0000};
          RAMP_CTRL_OFS:  rdData_nxt = DATA_W'(rampCtrl_r);
          RAMP_LEN_OFS:   rdData_nxt = DATA_W'(rampLen_r);
          REST_LEN_OFS:   rdData_nxt = DATA_W'(restLen_r);
          HOLDOFF_OFS:    rdData_nxt = DATA_W'(holdValue_r);
          STATUS_OFS:     rdData_nxt = {rampBusy, activeModeBit, holdCnt_r};
          default:        rdData_nxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      syncMask_r  <= SYNC_MASK_RESET;
      fsPending_r <= FS_RESET;
      syncSel_r   <= '0;
      rampCtrl_r  <= '0;
      rampLen_r   <= '0;
      restLen_r   <= '0;
      holdValue_r <= '0;
      regRdData   <= '0;
    end else begin
      syncMask_r  <= syncMask_nxt;
      fsPending_r <= fsPending_nxt;
      syncSel_r   <= syncSel_nxt;
      rampCtrl_r  <= rampCtrl_nxt;
      rampLen_r   <= rampLen_nxt;
      restLen_r   <= restLen_nxt;
      holdValue_r <= holdValue_nxt;
      regRdData   <= rdData_nxt;
    end
  end

  // Sync routing and hold-off counter.
  always_comb begin
    sync0Pass = syncPins[0] && syncMask_r[CHANNEL] && syncMask_r[MASK_BEAM_BIT];
    softBeam  = extWr.en && extWr.addr == SOFT_SYNC_ADDR &&
                extWr.data[SOFT_BEAM_BIT] && extWr.data[CHANNEL];
    beamSync_nxt = sync0Pass | softBeam;
    case (syncSel_r)
      2'h0:    muxSync = beamSync_nxt;
      2'h1:    muxSync = syncPins[1];
      2'h2:    muxSync = syncPins[2];
      2'h3:    muxSync = syncPins[3];
      default: muxSync = 1'b0;
    endcase
    tsLoad   = muxSync | (rampCtrl_r[SERIAL_SYNC_BIT] & serialSync);
    holdTrig = holdCnt_r == HOLDOFF_ONE;
    if (tsLoad) begin
      holdCnt_nxt = holdValue_r;
    end else if (holdCnt_r != '0) begin
      holdCnt_nxt = holdCnt_r - HOLDOFF_ONE;
    end else begin
      holdCnt_nxt = holdCnt_r;
    end
    fsActive_nxt = holdTrig ? fsPending_r : fsActive_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      holdCnt_r   <= '0;
      fsActive_r  <= FS_RESET;
      beamSyncOut <= 1'b0;
    end else begin
      holdCnt_r   <= holdCnt_nxt;
      fsActive_r  <= fsActive_nxt;
      beamSyncOut <= beamSync_nxt;
    end
  end

  // Ramp sequencer; coefficient fetches complete between samples.
  always_comb begin
    topStep     = interp ? {rampLen_r, 1'b1} : {1'b0, rampLen_r};
    state_nxt   = state_r;
    step_nxt    = step_r;
    restCnt_nxt = restCnt_r;
    fetchReq    = '0;
    mode_nxt    = activeModeBit;
    coeff_nxt   = coeff_r;
    if (pend_r.valid) begin
      coeff_nxt = (pend_r.odd && !pend_r.self) ? coeffAvg(memRdData, coeff_r) : memRdData;
    end
    case (state_r)
      RAMP_IDLE: begin
        if (holdTrig && rampEn) begin
          state_nxt = RAMP_ARM;
          step_nxt  = topStep;
          fetchReq  = mkFetch(topStep, interp, rampLen_r, 1'b0, 1'b1);
        end
      end
      RAMP_ARM: begin
        if (pend_r.valid) begin
          state_nxt = RAMP_DOWN;
        end
      end
      RAMP_DOWN: begin
        if (fsValid) begin
          if (step_r == '0) begin
            mode_nxt = pendingModeBit;
            step_nxt = '0;
            if (restLen_r == '0) begin
              state_nxt = RAMP_UP;
              fetchReq  = mkFetch('0, interp, rampLen_r, 1'b1, 1'b0);
            end else begin
              state_nxt   = RAMP_REST;
              restCnt_nxt = restLen_r;
            end
          end else begin
            step_nxt = step_r - 7'h01;
            fetchReq = mkFetch(step_r - 7'h01, interp, rampLen_r, 1'b0, 1'b0);
          end
        end
      end
      RAMP_REST: begin
        if (fsValid) begin
          if (restCnt_r == 6'h01) begin
            state_nxt = RAMP_UP;
            fetchReq  = mkFetch('0, interp, rampLen_r, 1'b1, 1'b0);
          end else begin
            restCnt_nxt = restCnt_r - 6'h01;
          end
        end
      end
      RAMP_UP: begin
        if (fsValid) begin
          if (step_r == topStep) begin
            state_nxt = RAMP_IDLE;
          end else begin
            step_nxt = step_r + 7'h01;
            fetchReq = mkFetch(step_r + 7'h01, interp, rampLen_r, 1'b1, 1'b0);
          end
        end
      end
      default: state_nxt = RAMP_IDLE;
    endcase
    halt_nxt = state_nxt == RAMP_REST;
    busy_nxt = state_nxt != RAMP_IDLE;
    // The idle level is the last coefficient applied, so the output holds after ramp-up.
    if (!rampEn) begin
      appliedCoeff = RAMP_UNITY;
    end else if (state_r == RAMP_REST) begin
      appliedCoeff = '0;
    end else begin
      appliedCoeff = {1'b0, coeff_r};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r       <= RAMP_IDLE;
      step_r        <= '0;
      restCnt_r     <= '0;
      coeff_r       <= COEFF_RESET;
      pend_r        <= '0;
      activeModeBit <= 1'b0;
      inputHalt     <= 1'b0;
      rampBusy      <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      step_r        <= step_nxt;
      restCnt_r     <= restCnt_nxt;
      coeff_r       <= coeff_nxt;
      pend_r        <= fetchReq;
      activeModeBit <= mode_nxt;
      inputHalt     <= halt_nxt;
      rampBusy      <= busy_nxt;
    end
  end

  assign fsFactor = legacyMode ? {fsActive_r[FS_W-2:0], 1'b0} : fsActive_r;

  fsr_coeff_mem #(.WIDTH(COEFF_W), .DEPTH(COEFF_DEPTH)) u_coeff_mem (
    .clk     (clk),
    .reset_n (reset_n),
    .wrEn    (coeffWr),
    .wrAddr  (regWr.addr[LEN_W-1:0]),
    .wrData  (regWr.data[COEFF_W-1:0]),
    .rdAddr  (fetchReq.addr),
    .rdData  (memRdData)
  );

  fsr_scale_mult #(.FACTOR_W(FS_W), .FRAC_W(FS_FRAC)) u_fine_mult (
    .clk       (clk),
    .reset_n   (reset_n),
    .inValid   (sampleValid),
    .inSample  (sampleIn),
    .factor    (fsFactor),
    .outValid  (fsValid),
    .outSample (fsSample)
  );

  fsr_scale_mult #(.FACTOR_W(RAMP_W), .FRAC_W(COEFF_W)) u_ramp_mult (
    .clk       (clk),
    .reset_n   (reset_n),
    .inValid   (fsValid),
    .inSample  (fsSample),
    .factor    (appliedCoeff),
    .outValid  (outValid),
    .outSample (outSample)
  );

  AST_HOLDOFF_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
    tsLoad |=> holdCnt_r == $past(holdValue_r))
    else $error("hold-off counter did not load programmed value");
  AST_HOLDOFF_STOP: assert property (@(posedge clk) disable iff (!reset_n)
    (holdCnt_r == HOLDOFF_ONE && !tsLoad) |=> holdCnt_r == '0 ##1 (holdCnt_r == '0 || $past(tsLoad)))
    else $error("hold-off counter did not stop at zero");
  AST_ZERO_BYPASS: assert property (@(posedge clk) disable iff (!reset_n)
    (tsLoad && !holdTrig && holdValue_r == '0) ##1 !tsLoad |->
      fsActive_r == $past(fsActive_r) && state_r == RAMP_IDLE
      || $past(state_r) != RAMP_IDLE)
    else $error("zero hold-off load caused an update");
  AST_SCALE_UPDATE: assert property (@(posedge clk) disable iff (!reset_n)
    holdTrig |=> fsActive_r == $past(fsPending_r))
    else $error("fine scale not updated on hold-off trigger");
  AST_BUSY_IGNORE: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r inside {RAMP_DOWN, RAMP_REST, RAMP_UP}) |=> state_r != RAMP_ARM)
    else $error("trigger accepted during a running ramp");
  AST_FIRST_ONLY: assert property (@(posedge clk) disable iff (!reset_n)
    (sync0Pass && syncMask_r[FIRST_ONLY_BIT] && !(regWr.en && regWr.addr == COMMON_MASK_ADDR))
      |=> syncMask_r == SYNC_MASK_RESET)
    else $error("first-sync-only did not clear the mask");
  AST_REST_QUIET: assert property (@(posedge clk) disable iff (!reset_n)
    (fsValid && rampEn && state_r == RAMP_REST) |-> inputHalt ##1 (outValid && outSample == '0))
    else $error("output not quiet during rest");
  AST_BYPASS: assert property (@(posedge clk) disable iff (!reset_n)
    (fsValid && !rampEn) |=> outSample == $past(fsSample))
    else $error("ramp bypass altered the sample");
  AST_SOFT_ROUTE: assert property (@(posedge clk) disable iff (!reset_n)
    (extWr.en && extWr.addr == SOFT_SYNC_ADDR && !extWr.data[CHANNEL] && !sync0Pass) |=> !beamSyncOut)
    else $error("software sync reached an unselected channel");

endmodule

// ### verilog/fsr_pkg.sv
package fsr_pkg;

  localparam int SAMPLE_W   = 16;
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 18;
  localparam int EXT_ADDR_W = 3;
  localparam int EXT_DATA_W = 8;

  // Host port addresses: page nibble in [11:8] selects the channel.
  localparam logic [ADDR_W-1:0]     COMMON_MASK_ADDR = 12'h001;
  localparam logic [7:0]            FINE_SCALE_OFS   = 8'h0e;
  localparam logic [7:0]            SYNC_SEL_OFS     = 8'h0f;
  localparam logic [7:0]            RAMP_CTRL_OFS    = 8'h16;
  localparam logic [7:0]            RAMP_LEN_OFS     = 8'h17;
  localparam logic [7:0]            REST_LEN_OFS     = 8'h18;
  localparam logic [7:0]            HOLDOFF_OFS      = 8'h19;
  localparam logic [7:0]            STATUS_OFS       = 8'h1a;
  localparam logic [1:0]            COEFF_PAGE       = 2'h1;
  localparam logic [EXT_ADDR_W-1:0] SOFT_SYNC_ADDR   = 3'h5;

  // Field positions.
  localparam int SYNC_SEL_LSB    = 16;
  localparam int RAMP_EN_BIT     = 0;
  localparam int RAMP_INTERP_BIT = 1;
  localparam int SERIAL_SYNC_BIT = 2;
  localparam int MASK_BEAM_BIT   = 6;
  localparam int FIRST_ONLY_BIT  = 7;
  localparam int SOFT_BEAM_BIT   = 6;

  // Number formats.
  localparam int FS_W        = 17;
  localparam int FS_FRAC     = 16;
  localparam int COEFF_W     = 14;
  localparam int COEFF_DEPTH = 64;
  localparam int RAMP_W      = COEFF_W + 1;
  localparam int HOLDOFF_W   = 16;
  localparam int STEP_W      = 7;
  localparam int LEN_W       = 6;

  localparam logic [LEN_W-1:0]     REST_MAX         = 6'h20;
  localparam logic [RAMP_W-1:0]    RAMP_UNITY       = 15'h4000;
  localparam logic [COEFF_W-1:0]   COEFF_RESET      = 14'h3fff;
  localparam logic [FS_W-1:0]      FS_RESET         = 17'h10000;
  localparam logic [7:0]           SYNC_MASK_RESET  = 8'h00;
  localparam logic [HOLDOFF_W-1:0] HOLDOFF_ONE      = 16'h0001;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } fsr_sample_s;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsr_reg_wr_s;

  typedef struct packed {
    logic                  en;
    logic [EXT_ADDR_W-1:0] addr;
    logic [EXT_DATA_W-1:0] data;
  } fsr_ext_wr_s;

  typedef struct packed {
    logic             valid;
    logic [LEN_W-1:0] addr;
    logic             odd;
    logic             self;
  } fsr_fetch_s;

  typedef enum logic [2:0] {
    RAMP_IDLE = 3'b000,
    RAMP_ARM  = 3'b001,
    RAMP_DOWN = 3'b011,
    RAMP_REST = 3'b010,
    RAMP_UP   = 3'b110
  } fsr_ramp_e;

endpackage

// ### verilog/fsr_scale_mult.sv
`timescale 1ns/1ps
module fsr_scale_mult
  import fsr_pkg::*;
#(
  parameter int FACTOR_W = FS_W,
  parameter int FRAC_W   = FS_FRAC
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                inValid,
  input  wire fsr_sample_s         inSample,
  input  wire logic [FACTOR_W-1:0] factor,
  output logic                     outValid,
  output fsr_sample_s              outSample
);

  localparam int PROD_W = SAMPLE_W + FACTOR_W + 1;

  if (FRAC_W >= FACTOR_W + SAMPLE_W || FRAC_W < 1) begin : g_bad_frac
    $error("fsr_scale_mult: fraction width out of range");
  end

  // Gains up to two can overflow the sample word, so results saturate.
  function automatic logic signed [SAMPLE_W-1:0] scaleSat(input logic signed [SAMPLE_W-1:0] s,
                                                          input logic [FACTOR_W-1:0]        f);
    logic signed [PROD_W-1:0] p;
    logic signed [PROD_W-1:0] maxV;
    logic signed [PROD_W-1:0] minV;
    p    = (PROD_W'(s) * $signed({1'b0, f})) >>> FRAC_W;
    maxV = PROD_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
    minV = -maxV - PROD_W'(1);
    if (p > maxV) begin
      return maxV[SAMPLE_W-1:0];
    end else if (p < minV) begin
      return minV[SAMPLE_W-1:0];
    end
    return p[SAMPLE_W-1:0];
  endfunction

  logic        valid_nxt;
  fsr_sample_s sample_nxt;

  always_comb begin
    valid_nxt    = inValid;
    sample_nxt   = outSample;
    if (inValid) begin
      sample_nxt.i = scaleSat(inSample.i, factor);
      sample_nxt.q = scaleSat(inSample.q, factor);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      outValid  <= 1'b0;
      outSample <= '0;
    end else begin
      outValid  <= valid_nxt;
      outSample <= sample_nxt;
    end
  end

endmodule
